// File: src/lps_supervisor.sv
// load switch protection supervisor top
`timescale 1ns/10ps
module lps_supervisor (
	input  wire logic                     CORE_CLK,        // 125 MHz core clock
	input  wire logic                     RESET,           // synchronous reset, high
	input  wire logic                     BAT_PRESENT,     // battery supply above 2.5 V
	input  wire logic                     BUS_PRESENT,     // VBUS present comparator
	input  wire logic                     IO_PRESENT,      // io supply present
	input  wire logic                     BUS_OVER_OVP,    // VBUS above overvoltage threshold
	input  wire logic                     BUS_BELOW_HYS,   // VBUS below threshold minus hysteresis
	input  wire logic                     BUS_ABOVE_UVLO,  // VBUS above lockout threshold
	input  wire logic                     ID_ACTIVE,       // ID comparator, accessory seen
	input  wire logic [lps_pkg::OCL_W-1:0] SWITCH_CURRENT, // measured load switch current code
	input  wire logic [lps_pkg::OCL_W-1:0] OCP_LEVEL,      // host programmed overcurrent level
	input  wire logic                     MIC_SEL_DP,      // request mic path to DP
	input  wire logic                     FLAG_CLEAR,      // host clears both flags, pulse
	output logic                          POWER_ON,        // device powered
	output logic                          SUPPLY_FROM_BUS, // supply taken from VBUS
	output logic                          DETECT_EN,       // detection enabled
	output logic                          I2C_EN,          // host port enabled
	output logic                          STANDBY,         // standby, nothing attached
	output logic                          ACCESSORY_SEEN,  // accessory inserted
	output logic                          LOAD_SWITCH_ON,  // load switch closed
	output logic                          OVERVOLTAGE_EVENT_FLAG, // sticky overvoltage flag
	output logic                          PROTECTION_CLEARED_FLAG, // sticky cleared flag
	output logic                          MIC_TO_BUS,      // mic path on VBUS
	output logic                          MIC_TO_DP        // mic path on DP
);
	import lps_pkg::*;

	// -------------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------------
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic [OCL_W-1:0] cur1_reg;
	logic [OCL_W-1:0] cur2_reg;

	assign raw_in = {MIC_SEL_DP, ID_ACTIVE, BUS_ABOVE_UVLO, BUS_BELOW_HYS,
		BUS_OVER_OVP, IO_PRESENT, BUS_PRESENT, BAT_PRESENT};

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			cur1_reg  <= '0;
			cur2_reg  <= '0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			cur1_reg  <= SWITCH_CURRENT;
			cur2_reg  <= cur1_reg;
		end
	end

	logic bat;
	logic bus;
	logic io;
	logic ovp;
	logic below_hys;
	logic above_uvlo;
	logic id_act;
	logic mic_dp;
	assign bat        = sync2_reg[0];
	assign bus        = sync2_reg[1];
	assign io         = sync2_reg[2];
	assign ovp        = sync2_reg[3];
	assign below_hys  = sync2_reg[4];
	assign above_uvlo = sync2_reg[5];
	assign id_act     = sync2_reg[6];
	assign mic_dp     = sync2_reg[7];

	// -------------------------------------------------------------------
	// supply decode
	// -------------------------------------------------------------------
	lps_supply_t supply;
	always_comb begin
		if (bat) begin
			supply = LPS_SUP_BAT;
		end else if (bus && !io) begin
			supply = LPS_SUP_BUS;
		end else begin
			// no supply, or VBUS/io without battery: held down
			supply = LPS_SUP_OFF;
		end
	end

	logic powered;
	logic ls_allowed;
	assign powered    = (supply != LPS_SUP_OFF);
	assign ls_allowed = powered && bus;

	// -------------------------------------------------------------------
	// qualification counters
	// -------------------------------------------------------------------
	lps_cnt_if rec_if ();
	lps_cnt_if ocp_if ();
	logic      over_cur;

	// the comparison uses the live host setting, so a rewrite takes effect at once
	assign over_cur = cur2_reg > OCP_LEVEL;

	lps_qual_cnt #(.LIMIT(RECOVERY_CYCLES)) u_recovery (
		.clk  (CORE_CLK),
		.rst  (RESET),
		.port (rec_if.cnt)
	);

	lps_qual_cnt #(.LIMIT(OCP_TIMEOUT_CYCLES)) u_ocp_timeout (
		.clk  (CORE_CLK),
		.rst  (RESET),
		.port (ocp_if.cnt)
	);

	// -------------------------------------------------------------------
	// supervisor state
	// -------------------------------------------------------------------
	typedef struct packed {
		lps_ls_state_t ls;
		logic          ov_flag;
		logic          clr_flag;
		logic          attached;
		logic          mic_dp;
	} lps_sup_t;

	lps_sup_t st_reg;
	lps_sup_t st_next;

	always_comb begin
		st_next = st_reg;
		rec_if.cond = 1'b0;
		ocp_if.cond = 1'b0;
		if (FLAG_CLEAR) begin
			st_next.ov_flag  = 1'b0;
			st_next.clr_flag = 1'b0;
		end
		st_next.attached = powered && (bus || id_act);
		st_next.mic_dp   = mic_dp;
		if (!powered) begin
			st_next = '0;
		end else begin
			case (st_reg.ls)
				LPS_LS_IDLE: begin
					if (ls_allowed && ovp) begin
						st_next.ls      = LPS_LS_OVP;
						st_next.ov_flag = 1'b1;
					end else if (ls_allowed) begin
						st_next.ls = LPS_LS_ON;
					end
				end
				LPS_LS_ON: begin
					ocp_if.cond = over_cur;
					if (!ls_allowed) begin
						st_next.ls = LPS_LS_IDLE;
					end else if (ovp) begin
						st_next.ls      = LPS_LS_OVP;
						st_next.ov_flag = 1'b1;
					end else if (ocp_if.done) begin
						st_next.ls = LPS_LS_OCP;
					end
				end
				LPS_LS_OVP: begin
					rec_if.cond = ls_allowed && !ovp && below_hys && above_uvlo;
					if (!ls_allowed) begin
						st_next.ls = LPS_LS_IDLE;
					end else if (rec_if.done) begin
						st_next.ls       = LPS_LS_ON;
						st_next.clr_flag = 1'b1;
					end
				end
				LPS_LS_OCP: begin
					// stays off until VBUS goes away, a fresh attach retries
					if (!ls_allowed) begin
						st_next.ls = LPS_LS_IDLE;
					end
				end
				default: begin
					st_next.ls = LPS_LS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	// switch drops combinationally on the synchronised comparator, well inside 1 us
	assign LOAD_SWITCH_ON = (st_reg.ls == LPS_LS_ON) && !ovp && ls_allowed;
	assign POWER_ON                = powered;
	assign SUPPLY_FROM_BUS         = (supply == LPS_SUP_BUS);
	assign DETECT_EN               = powered;
	assign I2C_EN                  = (supply == LPS_SUP_BAT) && io;
	assign STANDBY                 = !st_reg.attached;
	assign ACCESSORY_SEEN          = st_reg.attached;
	assign OVERVOLTAGE_EVENT_FLAG  = st_reg.ov_flag;
	assign PROTECTION_CLEARED_FLAG = st_reg.clr_flag;
	assign MIC_TO_DP               = st_reg.attached && st_reg.mic_dp;
	assign MIC_TO_BUS              = st_reg.attached && !st_reg.mic_dp;

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	AST_OVP_OPENS: assert property (@(posedge CORE_CLK) disable iff (RESET)
		ovp |-> !LOAD_SWITCH_ON)
		else $error("switch closed during overvoltage");
	AST_OVP_TIME: assert property (@(posedge CORE_CLK) disable iff (RESET)
		$rose(sync2_reg[3]) |-> ##[0:2] !LOAD_SWITCH_ON)
		else $error("switch not opened in time");
	AST_OVP_FLAG: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(st_reg.ls == LPS_LS_ON && ovp && ls_allowed) |=> OVERVOLTAGE_EVENT_FLAG)
		else $error("overvoltage flag not set");
	AST_RECOVER: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(st_reg.ls == LPS_LS_OVP) ##1 (st_reg.ls == LPS_LS_ON) |-> $past(rec_if.done, 1))
		else $error("recovery without deglitch");
	AST_CLR_FLAG: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(st_reg.ls == LPS_LS_OVP && rec_if.done && powered) |=> PROTECTION_CLEARED_FLAG)
		else $error("cleared flag not set");
	AST_POWER_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(!bus && !bat) |-> !POWER_ON && !LOAD_SWITCH_ON)
		else $error("powered without supply");
	AST_OCP_OFF: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(st_reg.ls == LPS_LS_ON && ocp_if.done && ls_allowed && !ovp)
		|=> st_reg.ls == LPS_LS_OCP)
		else $error("overcurrent did not disable switch");
	AST_I2C_EN: assert property (@(posedge CORE_CLK) disable iff (RESET)
		I2C_EN |-> io && bat)
		else $error("i2c enabled without supplies");
	AST_MIC_ONE: assert property (@(posedge CORE_CLK) disable iff (RESET)
		!(MIC_TO_BUS && MIC_TO_DP))
		else $error("mic path on both");
	AST_UNPOWERED: assert property (@(posedge CORE_CLK) disable iff (RESET)
		!powered |=> !OVERVOLTAGE_EVENT_FLAG && st_reg.ls == LPS_LS_IDLE)
		else $error("state kept while unpowered");
endmodule

// File: src/lps_pkg.sv
// constants and types shared by the load switch protection supervisor
// -----------------------------------------------------------------------
// Overview of operation
// - after power up or with no accessory detected, the device sits in standby
// - in standby, VBUS and ID comparators are watched for an inserted accessory
// - VBUS above the overvoltage threshold opens the load switch
// - the switch opens within 1 us of overvoltage, with no deglitch
// - overvoltage sets the overvoltage event flag, except while the switch is latched off by overcurrent (LPS_LS_OCP)
// - switch closes again after VBUS is in the safe window for the deglitch time
// - clearing of an overvoltage sets the protection cleared flag
// - no VBUS and battery below 2.5 V powers the device off
// - current above the overcurrent threshold starts a time-out
// - current still above threshold at time-out disables the load switch
// - the overcurrent level is a host-written setting the device compares against
// - battery supply is used when present, VBUS only when battery is absent
// - I2C is enabled only with both io supply and battery supply present
// - with battery present detection is on, load switch only with VBUS
// - with VBUS alone detection and load switch are on, I2C is off
// - the microphone path connects to exactly one of VBUS or DP while an accessory is seen, to neither in standby
// -----------------------------------------------------------------------
package lps_pkg;
	localparam int    CLK_PERIOD_NS      = 8;
	localparam int    OVP_OFF_MAX_NS     = 1000;
	localparam int    OVP_OFF_CYCLES     = OVP_OFF_MAX_NS / CLK_PERIOD_NS;
	localparam int    RECOVERY_TIME_US   = 10;
	localparam int    RECOVERY_CYCLES    = (RECOVERY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int    OCP_TIMEOUT_US     = 20;
	localparam int    OCP_TIMEOUT_CYCLES = (OCP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int    CNT_W              = 16;
	localparam int    OCL_W              = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

	typedef enum logic [1:0] {
		LPS_SUP_OFF,
		LPS_SUP_BAT,
		LPS_SUP_BUS
	} lps_supply_t;

	typedef enum logic [1:0] {
		LPS_LS_IDLE,
		LPS_LS_ON,
		LPS_LS_OVP,
		LPS_LS_OCP
	} lps_ls_state_t;
endpackage

// File: src/lps_cnt_if.sv
// interface carrying one qualified counter between supervisor and counter
`timescale 1ns/10ps
interface lps_cnt_if;
	logic cond;
	logic done;
	modport ctl (output cond, input done);
	modport cnt (input cond, output done);
endinterface

// File: src/lps_qual_cnt.sv
// counter that flags once a condition has held for LIMIT cycles
`timescale 1ns/10ps
module lps_qual_cnt #(
	parameter int LIMIT = 1
) (
	input  wire logic clk,      // core clock
	input  wire logic rst,      // synchronous reset, high
	lps_cnt_if.cnt    port      // condition in, done out
);
	import lps_pkg::*;
	localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} lps_qc_t;

	lps_qc_t state_reg;
	lps_qc_t state_next;

	// restarts from zero whenever the condition drops
	always_comb begin
		state_next = state_reg;
		if (!port.cond) begin
			state_next.cnt = CNT_ZERO;
		end else if (state_reg.cnt != LIM) begin
			state_next.cnt = state_reg.cnt + CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign port.done = port.cond && (state_reg.cnt == LIM);

	AST_CNT_RESTART: assert property (@(posedge clk) disable iff (rst)
		!port.cond |=> state_reg.cnt == CNT_ZERO)
		else $error("counter did not restart");
endmodule

// File: testbench/lps_bus_model.sv
// behavioural charger and VBUS comparator bank facing the supervisor
`timescale 1ns/10ps
module lps_bus_model #(
	parameter int PRES_MV = 3500, // presence level, plain default
	parameter int UVLO_MV = 4000, // lockout level, plain default
	parameter int OVP_MV  = 6000, // overvoltage level, plain default
	parameter int HYS_MV  = 200   // overvoltage hysteresis, plain default
) (
	input  wire logic        clk,        // core clock
	input  wire logic [15:0] volt_mv,    // commanded VBUS level
	output logic             present,    // VBUS present
	output logic             over_ovp,   // above overvoltage level
	output logic             below_hys,  // below level minus hysteresis
	output logic             above_uvlo  // above lockout level
);
	// a pulled-out charger reads 0 V, so every comparator except below_hys drops with it
	initial begin
		{present, over_ovp, below_hys, above_uvlo} = 4'h0;
	end
	always @(posedge clk) begin
		present    <= volt_mv > PRES_MV;
		over_ovp   <= volt_mv > OVP_MV;
		below_hys  <= volt_mv < (OVP_MV - HYS_MV);
		above_uvlo <= volt_mv > UVLO_MV;
	end
endmodule

// File: testbench/tb_load_switch_protection_supervisor.sv
// self-checking bench for the load switch protection supervisor
`timescale 1ns/10ps
module tb_load_switch_protection_supervisor;
	import lps_pkg::*;
	localparam logic [15:0] V_OK = 16'h1388, V_HI = 16'h1B58;
	localparam logic [15:0] V_BAND = 16'h170C, V_LOW = 16'h0ED8;
	logic        clk = 1'b0, rst = 1'b1, bat, io, id, sel, fclr;
	logic [15:0] volt;
	logic [7:0]  cur, lvl, l;
	logic [31:0] seed = 32'h00008D6D, r;
	logic [4:0]  e;
	logic        bus_p, ovp, hys, uvlo, pwr, frm, det, i2c, stby, seen, ls, ovf, clf, mb, md;
	int          n_fail = 0, check_count = 0;
	always #4 clk = ~clk;
	lps_bus_model i_bus (.clk(clk), .volt_mv(volt), .present(bus_p), .over_ovp(ovp),
		.below_hys(hys), .above_uvlo(uvlo));
	lps_supervisor i_dut (.CORE_CLK(clk), .RESET(rst), .BAT_PRESENT(bat), .BUS_PRESENT(bus_p),
		.IO_PRESENT(io), .BUS_OVER_OVP(ovp), .BUS_BELOW_HYS(hys), .BUS_ABOVE_UVLO(uvlo),
		.ID_ACTIVE(id), .SWITCH_CURRENT(cur), .OCP_LEVEL(lvl), .MIC_SEL_DP(sel),
		.FLAG_CLEAR(fclr), .POWER_ON(pwr), .SUPPLY_FROM_BUS(frm), .DETECT_EN(det),
		.I2C_EN(i2c), .STANDBY(stby), .ACCESSORY_SEEN(seen), .LOAD_SWITCH_ON(ls),
		.OVERVOLTAGE_EVENT_FLAG(ovf), .PROTECTION_CLEARED_FLAG(clf), .MIC_TO_BUS(mb),
		.MIC_TO_DP(md));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected {power, from bus, detect, i2c, switch}; battery absent with io is invalid
	function automatic logic [4:0] sup_exp(input logic b, input logic u, input logic o);
		logic p;
		p = b | (u & ~o);
		return {p, ~b & u & ~o, p, b & o, p & u};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic look();
		@(negedge clk);
	endtask
	task automatic chk(input string what, input logic seen_v, input logic exp_v);
		check_count++;
		if (seen_v !== exp_v) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, exp_v, seen_v);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wait_ls(input logic v, input int bound);
		for (int i = 0; i < bound && ls !== v; i++) look();
		chk("load switch wait", ls, v);
		if (ls !== v) close_out();
	endtask
	task automatic pulse_clear();
		cyc(1);
		fclr <= 1'b1;
		cyc(1);
		fclr <= 1'b0;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{bat, io, id, sel, fclr} = 5'h00;
		volt = 16'h0000;
		cur = 8'h00;
		lvl = 8'h80;
		cyc(16);
		rst <= 1'b0;
		look();
		chk("standby after reset", stby, 1'b1);
		chk("switch after reset", ls, 1'b0);
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			cyc(1);
			{bat, io} <= {c[2], c[0]};
			volt <= c[1] ? V_OK : 16'h0000;
			cyc(8);
			look();
			e = sup_exp(c[2], c[1], c[0]);
			chk("power on", pwr, e[4]);
			chk("supply from bus", frm, e[3]);
			chk("detect enable", det, e[2]);
			chk("i2c enable", i2c, e[1]);
			chk("load switch enable", ls, e[0]);
		end
		$display("test supply table done");
		cyc(1);
		volt <= 16'h0000;
		id <= 1'b1;
		cyc(6);
		look();
		chk("accessory seen", seen, 1'b1);
		chk("standby left", stby, 1'b0);
		for (int k = 0; k < 8; k++) begin
			r = rnd();
			cyc(1);
			sel <= r[0];
			cyc(5);
			look();
			chk("mic to dp", md, r[0]);
			chk("mic to bus", mb, ~r[0]);
		end
		cyc(1);
		id <= 1'b0;
		cyc(6);
		look();
		chk("standby again", stby, 1'b1);
		chk("mic released", mb | md, 1'b0);
		$display("test accessory and mic done");
		cyc(1);
		volt <= V_OK;
		cyc(10);
		look();
		chk("switch on with bus", ls, 1'b1);
		cyc(1);
		volt <= V_HI;
		cyc(5);
		look();
		chk("switch open on overvoltage", ls, 1'b0);
		cyc(2);
		look();
		chk("overvoltage flag", ovf, 1'b1);
		cyc(1);
		volt <= V_LOW;
		cyc(RECOVERY_CYCLES + 20);
		look();
		chk("held off below lockout", ls, 1'b0);
		cyc(1);
		volt <= V_BAND;
		cyc(RECOVERY_CYCLES + 20);
		look();
		chk("held off in hysteresis", ls, 1'b0);
		cyc(1);
		volt <= V_OK;
		cyc(RECOVERY_CYCLES / 2);
		volt <= V_BAND;
		cyc(4);
		volt <= V_OK;
		cyc(RECOVERY_CYCLES - 10);
		look();
		chk("deglitch restarted", ls, 1'b0);
		wait_ls(1'b1, 40);
		chk("cleared flag", clf, 1'b1);
		chk("overvoltage flag sticky", ovf, 1'b1);
		pulse_clear();
		cyc(4);
		look();
		chk("cleared flag wiped", clf, 1'b0);
		chk("overvoltage flag wiped", ovf, 1'b0);
		$display("test overvoltage done");
		r = rnd();
		l = 8'h14 + {1'b0, r[6:0]};
		cyc(1);
		lvl <= l;
		cur <= l;
		cyc(OCP_TIMEOUT_CYCLES + 50);
		look();
		chk("no trip at level", ls, 1'b1);
		cyc(1);
		cur <= l + 8'h01;
		cyc(OCP_TIMEOUT_CYCLES / 2);
		cur <= l;
		cyc(3);
		cur <= l + 8'h01 + {7'h00, r[7]};
		cyc(OCP_TIMEOUT_CYCLES - 20);
		look();
		chk("time-out restarted", ls, 1'b1);
		wait_ls(1'b0, 60);
		cyc(1);
		cur <= 8'h00;
		cyc(20);
		look();
		chk("overcurrent latched off", ls, 1'b0);
		cyc(1);
		volt <= 16'h0000;
		cyc(8);
		volt <= V_OK;
		wait_ls(1'b1, 20);
		$display("test overcurrent done");
		close_out();
	end
endmodule
